//--- lpm_ctrl.v
// Low-power mode controller: halt-all and CPU-only halt sequencing with AXI4-Lite registers
//
// Overview of operation
// R1: Halt-all stops the serial port baud clock; master shifting ends.
// R2: Halt-all clears master select, leaving the serial port as slave.
// R3: Halt-all during a mastered serial transfer aborts that transfer.
// R4: Reset exit from halt-all clears serial control and status, port disabled.
// R5: A slave-configured serial port keeps shifting during halt-all.
// R6: Serial flags held back in halt-all until interrupt pin or codec wakes.
// R7: No collision or mode-fault detection during halt-all.
// R8: CPU-only halt stops CPU clock; timer, codec, serial port keep running.
// R9: CPU-only halt ends on timer, codec, serial interrupt, or low pins.
// R10: Watchdog and slow-clock detector run in CPU-only halt; software wakes often.
// R11: Timer always counts in CPU-only halt; codec and serial may be off.
// R12: Non-reset exit from CPU-only halt keeps all peripheral state.
// R13: Reset exit from CPU-only halt returns peripherals to disabled reset state.
// R14: Halt-all turns the oscillator off, halting CPU and peripheral clocks.
// R15: Halt-all wakes only on low interrupt pin, codec falling edge, reset.
// R16: After halt-all, wait 4064 cycles before fetch, or 96 with skip bit.
// R17: Halt-all inhibits watchdog counter and slow-clock detector.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "lpm_defines.vh"

module lpm_ctrl #(
    parameter CNT_WIDTH = `LPM_CNT_WIDTH
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write address
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // CPU mode entry requests
    input wire cpu_stop_req,
    input wire cpu_wait_req,
    // Peripheral interrupts and serial master busy, same clock
    input wire timer_irq,
    input wire pulse_symbol_codec_irq,
    input wire spi_irq,
    input wire spi_master_busy,
    // External pins, asynchronous
    input wire irq_pin_n,
    input wire reset_pin_n,
    input wire codec_receive_input,
    // Clock gating
    output reg osc_run_q,
    output reg cpu_clk_en_q,
    output reg fetch_en_q,
    output reg timer_run_q,
    output reg codec_run_q,
    // Serial port control
    output reg spi_baud_en_q,
    output reg master_select_q,
    output reg spi_enable_q,
    output reg spi_abort_q,
    output reg spi_slave_run_q,
    output reg spi_flag_hold_q,
    output reg spi_protect_en_q,
    // Supervisory timers and peripheral reset
    output reg watchdog_run_q,
    output reg slow_clk_det_run_q,
    output reg periph_reset_q,
    // Interrupt
    output wire irq
);

    // ==========================================
    // States
    localparam [3:0] ST_RUN = 4'b0001;
    localparam [3:0] ST_WAIT = 4'b0010;
    localparam [3:0] ST_STOP = 4'b0100;
    localparam [3:0] ST_START = 4'b1000;
    localparam [CNT_WIDTH-1:0] DLY_LONG = `LPM_START_LONG;
    localparam [CNT_WIDTH-1:0] DLY_SHORT = `LPM_START_SHORT;

    reg [3:0] state_q;
    reg [3:0] state_d;
    reg [3:0] ctrl_q;
    reg [`LPM_EV_WIDTH-1:0] sts_q;
    reg [`LPM_EV_WIDTH-1:0] mask_q;
    reg [`LPM_EV_WIDTH-1:0] ev;
    reg dly_load;
    reg [CNT_WIDTH-1:0] dly_value;
    wire dly_busy;
    wire dly_done;

    // ==========================================
    // Pin synchronisers
    reg [1:0] irq_sync_q;
    reg [1:0] rst_sync_q;
    reg [1:0] rx_sync_q;
    reg rx_prev_q;
    wire irq_low = ~irq_sync_q[1];
    wire rst_low = ~rst_sync_q[1];
    wire rx_fall = rx_prev_q & ~rx_sync_q[1];

    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_sync_q <= 2'b11;
            rst_sync_q <= 2'b11;
            rx_sync_q <= 2'b11;
            rx_prev_q <= 1'b1;
        end else begin
            irq_sync_q <= {irq_sync_q[0], irq_pin_n};
            rst_sync_q <= {rst_sync_q[0], reset_pin_n};
            rx_sync_q <= {rx_sync_q[0], codec_receive_input};
            rx_prev_q <= rx_sync_q[1];
        end
    end

    // ==========================================
    // Mode sequencer
    wire wait_wake = timer_irq | pulse_symbol_codec_irq | spi_irq | irq_low; // R9
    wire stop_wake = irq_low | rx_fall; // R15

    always @* begin
        state_d = state_q;
        dly_load = 1'b0;
        dly_value = DLY_LONG;
        ev = {`LPM_EV_WIDTH{1'b0}};
        if (rst_low) begin
            state_d = ST_START;
            dly_load = 1'b1;
            if (state_q != ST_START) begin
                ev[`LPM_EV_RESET_EXIT] = state_q[1] | state_q[2];
            end
        end else begin
            case (state_q)
                ST_RUN: begin
                    if (cpu_stop_req) begin
                        state_d = ST_STOP;
                        ev[`LPM_EV_STOP_ENTER] = 1'b1;
                    end else if (cpu_wait_req) begin
                        state_d = ST_WAIT;
                        ev[`LPM_EV_WAIT_ENTER] = 1'b1;
                    end
                end
                ST_WAIT: begin
                    if (wait_wake) begin
                        state_d = ST_RUN; // R12
                        ev[`LPM_EV_WAIT_EXIT] = 1'b1;
                    end
                end
                ST_STOP: begin
                    if (stop_wake) begin
                        state_d = ST_START;
                        dly_load = 1'b1;
                        dly_value = ctrl_q[`LPM_CTRL_SKIP_BIT] ? DLY_SHORT : DLY_LONG; // R16
                        ev[`LPM_EV_STOP_EXIT] = 1'b1;
                    end
                end
                ST_START: begin
                    if (dly_done) begin
                        state_d = ST_RUN;
                    end
                end
                default: begin
                    state_d = ST_RUN;
                end
            endcase
        end
    end

    lpm_delay_counter #(
        .WIDTH(CNT_WIDTH)
    ) u_delay (
        .aclk(aclk),
        .aresetn(aresetn),
        .load(dly_load),
        .load_value(dly_value),
        .busy(dly_busy),
        .done_q(dly_done)
    );

    // ==========================================
    // AXI4-Lite slave
    reg aw_held_q;
    reg w_held_q;
    reg [3:0] aw_addr_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held_q & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    wire do_write = aw_held_q & w_held_q;
    wire wr_ctrl = do_write & (aw_addr_q == `LPM_CTRL_OFFS) & w_strb_q[0];
    wire wr_sts = do_write & (aw_addr_q == `LPM_INT_STS_OFFS) & w_strb_q[0];
    wire wr_mask = do_write & (aw_addr_q == `LPM_INT_MASK_OFFS) & w_strb_q[0];

    function mapped;
        input [3:0] addr;
        begin
            mapped = (addr == `LPM_CTRL_OFFS) || (addr == `LPM_STATE_OFFS) ||
                     (addr == `LPM_INT_STS_OFFS) || (addr == `LPM_INT_MASK_OFFS);
        end
    endfunction

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_addr_q <= 4'h0;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `LPM_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `LPM_RESP_OKAY;
            s_axi_rdata <= 32'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(aw_addr_q) ? `LPM_RESP_OKAY : `LPM_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= mapped(s_axi_araddr) ? `LPM_RESP_OKAY : `LPM_RESP_SLVERR;
                case (s_axi_araddr)
                    `LPM_CTRL_OFFS: s_axi_rdata <= {28'h0, ctrl_q};
                    `LPM_STATE_OFFS: s_axi_rdata <= {27'h0, dly_busy, state_q};
                    `LPM_INT_STS_OFFS: s_axi_rdata <= {27'h0, sts_q};
                    `LPM_INT_MASK_OFFS: s_axi_rdata <= {27'h0, mask_q};
                    default: s_axi_rdata <= 32'h0;
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ==========================================
    // State, control, interrupt registers
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ST_RUN;
            ctrl_q <= `LPM_CTRL_RESET;
            sts_q <= {`LPM_EV_WIDTH{1'b0}};
            mask_q <= {`LPM_EV_WIDTH{1'b0}};
        end else begin
            state_q <= state_d;
            if (rst_low) begin
                ctrl_q <= `LPM_CTRL_RESET; // R4 R13
            end else begin
                if (wr_ctrl) begin
                    ctrl_q <= w_data_q[3:0];
                end
                if (state_d == ST_STOP) begin
                    ctrl_q[`LPM_CTRL_MSEL_BIT] <= 1'b0; // R2
                end
            end
            // Set wins over write-one-to-clear
            sts_q <= (sts_q & ~(wr_sts ? w_data_q[`LPM_EV_WIDTH-1:0] : {`LPM_EV_WIDTH{1'b0}})) | ev;
            if (wr_mask) begin
                mask_q <= w_data_q[`LPM_EV_WIDTH-1:0];
            end
        end
    end

    assign irq = |(sts_q & mask_q);

    // ==========================================
    // Peripheral and clock controls
    wire in_stop = (state_q == ST_STOP);
    wire spi_on = ctrl_q[`LPM_CTRL_SPI_EN_BIT];
    wire msel = ctrl_q[`LPM_CTRL_MSEL_BIT];

    always @(posedge aclk) begin
        if (!aresetn) begin
            osc_run_q <= 1'b1;
            cpu_clk_en_q <= 1'b1;
            fetch_en_q <= 1'b1;
            timer_run_q <= 1'b1;
            codec_run_q <= 1'b0;
            spi_baud_en_q <= 1'b0;
            master_select_q <= 1'b0;
            spi_enable_q <= 1'b0;
            spi_abort_q <= 1'b0;
            spi_slave_run_q <= 1'b0;
            spi_flag_hold_q <= 1'b0;
            spi_protect_en_q <= 1'b1;
            watchdog_run_q <= 1'b1;
            slow_clk_det_run_q <= 1'b1;
            periph_reset_q <= 1'b0;
        end else begin
            osc_run_q <= ~in_stop; // R14
            cpu_clk_en_q <= (state_q == ST_RUN); // R8
            fetch_en_q <= (state_q == ST_RUN); // R16
            timer_run_q <= ~in_stop; // R11
            codec_run_q <= ~in_stop & ctrl_q[`LPM_CTRL_CODEC_EN_BIT]; // R8
            spi_baud_en_q <= ~in_stop & spi_on & msel; // R1
            master_select_q <= msel;
            spi_enable_q <= spi_on;
            spi_abort_q <= (state_q == ST_RUN) & (state_d == ST_STOP) & msel & spi_master_busy; // R3
            spi_slave_run_q <= spi_on & ~msel; // R5
            spi_flag_hold_q <= in_stop; // R6
            spi_protect_en_q <= ~in_stop; // R7
            watchdog_run_q <= ~in_stop; // R10 R17
            slow_clk_det_run_q <= ~in_stop; // R10 R17
            periph_reset_q <= rst_low; // R4 R13
        end
    end

endmodule

`default_nettype wire

//--- lpm_defines.vh
// Constants for the low-power mode controller
`ifndef LPM_DEFINES_VH
`define LPM_DEFINES_VH

// ==========================================
// Register byte offsets
`define LPM_CTRL_OFFS 4'h0
`define LPM_STATE_OFFS 4'h4
`define LPM_INT_STS_OFFS 4'h8
`define LPM_INT_MASK_OFFS 4'hc

// ==========================================
// Control register fields
`define LPM_CTRL_SKIP_BIT 0
`define LPM_CTRL_CODEC_EN_BIT 1
`define LPM_CTRL_SPI_EN_BIT 2
`define LPM_CTRL_MSEL_BIT 3
`define LPM_CTRL_RESET 4'h0

// ==========================================
// Interrupt status fields
`define LPM_EV_STOP_ENTER 0
`define LPM_EV_STOP_EXIT 1
`define LPM_EV_WAIT_ENTER 2
`define LPM_EV_WAIT_EXIT 3
`define LPM_EV_RESET_EXIT 4
`define LPM_EV_WIDTH 5

// ==========================================
// Start-up delays in instruction cycles
`define LPM_START_LONG 12'hfe0
`define LPM_START_SHORT 12'h060
`define LPM_CNT_WIDTH 12

// ==========================================
// Bus answers
`define LPM_RESP_OKAY 2'b00
`define LPM_RESP_SLVERR 2'b10

`endif

//--- lpm_delay_counter.v
// Start-up delay counter for the low-power mode controller
`timescale 1ns/1ps
`default_nettype none

module lpm_delay_counter #(
    parameter WIDTH = 12
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Control
    input wire load,
    input wire [WIDTH-1:0] load_value,
    // Status
    output wire busy,
    output reg done_q
);

    reg [WIDTH-1:0] count_q;

    assign busy = (count_q != {WIDTH{1'b0}});

    always @(posedge aclk) begin
        if (!aresetn) begin
            count_q <= {WIDTH{1'b0}};
            done_q <= 1'b0;
        end else if (load) begin
            count_q <= load_value;
            done_q <= 1'b0;
        end else begin
            done_q <= (count_q == {{(WIDTH-1){1'b0}}, 1'b1});
            if (busy) begin
                count_q <= count_q - {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule

`default_nettype wire

//--- lpm_cpu_model.sv
// CPU model issuing halt-all and CPU-only halt requests
`timescale 1ns/1ps
`default_nettype none
module lpm_cpu_model (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bench commands and core state
    input wire logic go_stop,
    input wire logic go_wait,
    input wire logic fetch_en_q,
    // Requests to the controller
    output logic cpu_stop_req,
    output logic cpu_wait_req
);
    // An instruction only executes while fetching; one-cycle pulse
    always @(posedge aclk) begin
        if (!aresetn) begin
            cpu_stop_req <= 1'b0;
            cpu_wait_req <= 1'b0;
        end else begin
            cpu_stop_req <= go_stop && fetch_en_q && !cpu_stop_req;
            cpu_wait_req <= go_wait && !go_stop && fetch_en_q && !cpu_wait_req;
        end
    end
endmodule
`default_nettype wire

//--- lpm_ctrl_sva.sv
// Assertions on the low-power mode controller ports
`timescale 1ns/1ps
`default_nettype none
module lpm_ctrl_sva (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Observed outputs
    input wire logic osc_run_q,
    input wire logic cpu_clk_en_q,
    input wire logic fetch_en_q,
    input wire logic timer_run_q,
    input wire logic spi_baud_en_q,
    input wire logic master_select_q,
    input wire logic spi_enable_q,
    input wire logic spi_abort_q,
    input wire logic spi_flag_hold_q,
    input wire logic spi_protect_en_q,
    input wire logic watchdog_run_q,
    input wire logic slow_clk_det_run_q,
    input wire logic periph_reset_q
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_pulse;
        spi_abort_q ##1 !spi_abort_q;
    endsequence
    property p_baud; !osc_run_q |-> !spi_baud_en_q; endproperty
    a_baud: assert property (p_baud) else $error("baud clock runs in halt-all");
    property p_msel; !osc_run_q |-> !master_select_q; endproperty
    a_msel: assert property (p_msel) else $error("master select kept in halt-all");
    property p_abort; spi_abort_q |=> !osc_run_q; endproperty
    a_abort: assert property (p_abort) else $error("abort outside halt-all");
    property p_pulse; $rose(spi_abort_q) |-> s_pulse; endproperty
    a_pulse: assert property (p_pulse) else $error("abort not one cycle");
    property p_flag; !osc_run_q |-> spi_flag_hold_q && !spi_protect_en_q; endproperty
    a_flag: assert property (p_flag) else $error("flags or protection live in halt-all");
    property p_wd; !osc_run_q |-> !watchdog_run_q && !slow_clk_det_run_q; endproperty
    a_wd: assert property (p_wd) else $error("supervisors run in halt-all");
    property p_run; osc_run_q |-> watchdog_run_q && slow_clk_det_run_q && timer_run_q; endproperty
    a_run: assert property (p_run) else $error("timer or supervisor stopped");
    property p_cpu; !osc_run_q |-> !cpu_clk_en_q && !fetch_en_q; endproperty
    a_cpu: assert property (p_cpu) else $error("cpu clock in halt-all");
    property p_fetch; fetch_en_q |-> cpu_clk_en_q; endproperty
    a_fetch: assert property (p_fetch) else $error("fetch without cpu clock");
    property p_prst; periph_reset_q |-> ##[0:2] (!spi_enable_q && !master_select_q); endproperty
    a_prst: assert property (p_prst) else $error("serial port kept after reset");
endmodule
bind lpm_ctrl lpm_ctrl_sva u_sva (.*);
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the low-power mode controller
`timescale 1ns/1ps
`default_nettype none
`include "lpm_defines.vh"
module testbench;
    typedef struct packed {logic [3:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] rsp;} lpm_row_t;
    lpm_row_t rows [4] = '{'{4'h0, 32'hf, 32'hf, 2'b00}, '{4'hc, 32'h15, 32'h15, 2'b00},
        '{4'h2, 32'h1, 32'h0, 2'b10}, '{4'h0, 32'hc, 32'hc, 2'b00}};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb, wk;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, go_stop, go_wait;
    logic cpu_stop_req, cpu_wait_req, timer_irq, pulse_symbol_codec_irq, spi_irq, spi_master_busy;
    logic irq_pin_n, reset_pin_n, codec_receive_input, osc_run_q, cpu_clk_en_q, fetch_en_q, timer_run_q;
    logic codec_run_q, spi_baud_en_q, master_select_q, spi_enable_q, spi_abort_q, spi_slave_run_q;
    logic spi_flag_hold_q, spi_protect_en_q, watchdog_run_q, slow_clk_det_run_q, periph_reset_q, irq;
    logic ab_seen = 1'b0;
    int errors = 0;
    int n_compared = 0;
    int cycles = 0;
    assign {spi_irq, pulse_symbol_codec_irq, timer_irq} = wk[2:0];
    assign irq_pin_n = !wk[3];
    lpm_ctrl #(.CNT_WIDTH(`LPM_CNT_WIDTH)) dut (.*);
    lpm_cpu_model u_cpu (.*);
    always #12.5 aclk = ~aclk;
    always @(posedge aclk) begin
        ab_seen <= ab_seen | (spi_abort_q === 1'b1);
        cycles++;
        if (cycles == 30000) begin
            errors++;
            stop_test;
        end
    end
    task stop_test;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task chkr(input string nm, input int lo, input int hi, input int g);
        n_compared++;
        if (g < lo || g > hi) begin
            errors++;
            $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask
    task cyc(input int k);
        repeat (k) @(posedge aclk);
    endtask
    task axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            r = s_axi_bresp;
        end while (s_axi_bvalid !== 1'b1 && n < 50);
        if (n >= 50) errors++;
    endtask
    task axr(input logic [3:0] a, output logic [31:0] v, output logic [1:0] r);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            v = s_axi_rdata;
            r = s_axi_rresp;
        end while (s_axi_rvalid !== 1'b1 && n < 50);
        if (n >= 50) errors++;
    endtask
    task enter(input logic stp);
        int n;
        n = 0;
        if (stp) go_stop <= 1'b1;
        else go_wait <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
        end while (!(cpu_stop_req || cpu_wait_req) && n < 50);
        go_stop <= 1'b0;
        go_wait <= 1'b0;
        cyc(3);
    endtask
    task until_fetch(output int n);
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (fetch_en_q !== 1'b1 && n < 5000);
    endtask
    initial begin
        logic [31:0] v;
        logic [1:0] r;
        int n;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, wk} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {go_stop, go_wait, spi_master_busy} = '0;
        s_axi_wstrb = 4'hf;
        reset_pin_n = 1'b1;
        codec_receive_input = 1'b1;
        cyc(10);
        aresetn <= 1'b1;
        cyc(1);
        axr(`LPM_STATE_OFFS, v, r);
        chk("state", 32'h1, v);
        foreach (rows[i]) begin
            axw(rows[i].a, rows[i].d, r);
            chk("wresp", rows[i].rsp, r);
            axr(rows[i].a, v, r);
            chk("rdata", rows[i].e, v);
            chk("rresp", rows[i].rsp, r);
        end
        chk("baud_en", 1'b1, spi_baud_en_q);
        spi_master_busy <= 1'b1;
        enter(1'b1);
        spi_master_busy <= 1'b0;
        chk("abort", 1'b1, ab_seen);
        chk("baud_en", 1'b0, spi_baud_en_q);
        chk("master_select", 1'b0, master_select_q);
        chk("osc_run", 1'b0, osc_run_q);
        chk("watchdog", 1'b0, watchdog_run_q);
        chk("flag_hold", 1'b1, spi_flag_hold_q);
        chk("protect", 1'b0, spi_protect_en_q);
        wk <= 4'h7;
        cyc(20);
        chk("osc_run", 1'b0, osc_run_q);
        wk <= 4'h8;
        until_fetch(n);
        wk <= 4'h0;
        chkr("long delay", 4064, 4076, n);
        axr(`LPM_INT_STS_OFFS, v, r);
        chk("status", 32'h3, v);
        chk("irq", 1'b1, irq);
        axw(`LPM_INT_MASK_OFFS, 32'h0, r);
        chk("irq", 1'b0, irq);
        axw(`LPM_INT_STS_OFFS, 32'h1f, r);
        axr(`LPM_INT_STS_OFFS, v, r);
        chk("status", 32'h0, v);
        axw(`LPM_CTRL_OFFS, 32'h5, r);
        enter(1'b1);
        chk("slave_run", 1'b1, spi_slave_run_q);
        codec_receive_input <= 1'b0;
        until_fetch(n);
        codec_receive_input <= 1'b1;
        chkr("short delay", 96, 108, n);
        axw(`LPM_CTRL_OFFS, 32'h6, r);
        for (int i = 0; i < 4; i++) begin
            enter(1'b0);
            chk("cpu_clk_en", 1'b0, cpu_clk_en_q);
            chk("codec_run", 1'b1, codec_run_q);
            chk("timer_run", 1'b1, timer_run_q);
            chk("watchdog", 1'b1, watchdog_run_q & slow_clk_det_run_q);
            wk <= 4'h1 << i;
            n = 0;
            do begin
                @(posedge aclk);
                n++;
            end while (cpu_clk_en_q !== 1'b1 && n < 50);
            wk <= 4'h0;
            chkr("wake", 1, 8, n);
        end
        axr(`LPM_CTRL_OFFS, v, r);
        chk("ctrl kept", 32'h6, v);
        for (int k = 0; k < 2; k++) begin
            axw(`LPM_CTRL_OFFS, 32'he, r);
            enter(k == 0);
            reset_pin_n <= 1'b0;
            cyc(4);
            chk("periph_reset", 1'b1, periph_reset_q);
            axr(`LPM_CTRL_OFFS, v, r);
            chk("ctrl cleared", 32'h0, v);
            reset_pin_n <= 1'b1;
            until_fetch(n);
            chkr("reset delay", 4064, 4076, n);
            chk("spi_enable", 1'b0, spi_enable_q);
        end
        stop_test;
    end
endmodule
`default_nettype wire
